// ==== addr_gen.sv ====
`timescale 1ns/1ps
`include "exec_regs.svh"
// a = base register, imm = displacement, sel = access size
module addr_gen (
   op_lane_if.unit ln
);
   exec_pkg::word_t disp;

   always_comb begin
      disp = {{16{ln.imm[15]}}, ln.imm};
      // masking the displacement, not the sum: a misaligned base still yields misaligned addresses
      unique case (ln.sel)
         `LANE_HALF: disp[0] = 1'b0;
         `LANE_WORD: disp[1:0] = 2'b00;
         default: disp = disp;
      endcase
   end

   assign ln.res = ln.a + disp;
   assign ln.cy = 1'b0;
endmodule

// ==== exec_pkg.sv ====
package exec_pkg;
   typedef enum logic [3:0] {
      OP_LSHIFT_IMM,
      OP_RSHIFT_REG,
      OP_RSHIFT_IMM,
      OP_BYTE_WRITE,
      OP_HALF_WRITE,
      OP_WORD_WRITE,
      OP_SYSREG_READ,
      OP_INT_MINUS,
      OP_FLOAT_MINUS,
      OP_SW_TRAP,
      OP_FLOAT_TRUNC,
      OP_XOR_REG,
      OP_XOR_IMM,
      OP_BSTR_XOR,
      OP_BSTR_XNOR
   } op_e;

   typedef logic [31:0] word_t;
endpackage

// ==== exec_regs.svh ====
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// status word bit positions
`define PSW_Z_BIT 0
`define PSW_S_BIT 1
`define PSW_OV_BIT 2
`define PSW_CY_BIT 3
`define PSW_INTDIS_BIT 12
`define PSW_AFLT_BIT 13
`define PSW_FIS_BIT 14
`define PSW_NMIP_BIT 15

// reset values
`define PSW_RESET 32'h0000_8000
`define SAVE_RESET 32'h0000_0000
`define CAUSE_RESET 32'h0000_0000

// system register numbers
`define SR_NRM_PC 5'h00
`define SR_NRM_ST 5'h01
`define SR_FAT_PC 5'h02
`define SR_FAT_ST 5'h03
`define SR_CAUSE 5'h04
`define SR_STATUS 5'h05

// trap handler and cause code layout
`define TRAP_VEC_BASE 32'hffff_ff00
`define TRAP_CODE_BASE 16'hff00
`define TRAP_VEC_SHIFT 4

// lane selects
`define LANE_FSUB 2'h0
`define LANE_FTRUNC 2'h1
`define LANE_BYTE 2'h0
`define LANE_HALF 2'h1
`define LANE_WORD 2'h2

`endif

// ==== exec_unit.sv ====
`timescale 1ns/1ps
`include "exec_regs.svh"
module exec_unit (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // instruction issue
   input wire logic OP_VALID,
   input wire exec_pkg::op_e OP_CODE,
   input wire exec_pkg::word_t SRC_VAL,
   input wire exec_pkg::word_t DST_VAL,
   input wire logic [15:0] IMM16,
   input wire logic [4:0] SEL5,
   input wire exec_pkg::word_t RET_PC,
   // status word load
   input wire logic STATUS_WE,
   input wire exec_pkg::word_t STATUS_WDATA,
   // result write-back
   output logic DONE,
   output logic GPR_WE,
   output logic BSTR_WE,
   output exec_pkg::word_t RESULT,
   // memory write
   output logic MEM_WE,
   output exec_pkg::word_t MEM_ADDR,
   output exec_pkg::word_t MEM_WDATA,
   output logic [3:0] MEM_BE,
   // trap
   output logic TRAP_TAKEN,
   output exec_pkg::word_t TRAP_PC,
   // state
   output exec_pkg::word_t STATUS
);
   op_lane_if fp_ln ();
   op_lane_if ag_ln ();

   fp_unit u_fp (
      .ln(fp_ln)
   );

   addr_gen u_ag (
      .ln(ag_ln)
   );

   exec_pkg::word_t status_q, status_d;
   exec_pkg::word_t nrm_pc_q, nrm_st_q, fat_pc_q, fat_st_q, cause_q;
   exec_pkg::word_t res_d, result_q;
   logic gpr_we_d, bstr_we_d, mem_we_d, trap_d;
   logic done_q, gpr_we_q, bstr_we_q, mem_we_q, trap_q;
   logic flags_upd, cy_upd, ov_d, cy_d;
   logic [32:0] wide;
   logic [3:0] be_d, be_q;
   exec_pkg::word_t wdata_d, wdata_q, addr_q, trap_pc_q;
   logic fis;
   logic is_trap;

   function automatic exec_pkg::word_t sysreg_sel(input logic [4:0] num,
                                                  input exec_pkg::word_t st);
      unique case (num)
         `SR_NRM_PC: return nrm_pc_q;
         `SR_NRM_ST: return nrm_st_q;
         `SR_FAT_PC: return fat_pc_q;
         `SR_FAT_ST: return fat_st_q;
         `SR_CAUSE: return cause_q;
         `SR_STATUS: return st;
         default: return 32'h0000_0000;
      endcase
   endfunction

   assign fis = status_q[`PSW_FIS_BIT];
   assign is_trap = OP_VALID && (OP_CODE == exec_pkg::OP_SW_TRAP);

   assign fp_ln.a = DST_VAL;
   assign fp_ln.b = SRC_VAL;
   assign fp_ln.imm = IMM16;
   assign fp_ln.sel = (OP_CODE == exec_pkg::OP_FLOAT_TRUNC) ? `LANE_FTRUNC : `LANE_FSUB;

   assign ag_ln.a = SRC_VAL;
   assign ag_ln.b = DST_VAL;
   assign ag_ln.imm = IMM16;
   always_comb begin
      unique case (OP_CODE)
         exec_pkg::OP_HALF_WRITE: ag_ln.sel = `LANE_HALF;
         exec_pkg::OP_WORD_WRITE: ag_ln.sel = `LANE_WORD;
         default: ag_ln.sel = `LANE_BYTE;
      endcase
   end

   // datapath: result, write enables and new flag values
   always_comb begin
      res_d = DST_VAL;
      gpr_we_d = 1'b0;
      bstr_we_d = 1'b0;
      mem_we_d = 1'b0;
      trap_d = 1'b0;
      flags_upd = 1'b0;
      cy_upd = 1'b0;
      cy_d = 1'b0;
      ov_d = 1'b0;
      wide = 33'h0;
      be_d = 4'h0;
      wdata_d = DST_VAL;
      unique case (OP_CODE)
         exec_pkg::OP_LSHIFT_IMM: begin
            wide = {1'b0, DST_VAL} << {28'h0, SEL5};
            res_d = wide[31:0];
            cy_d = wide[32];
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
            cy_upd = 1'b1;
         end
         exec_pkg::OP_RSHIFT_REG: begin
            // zero enters the msb; carry is the last bit shifted out
            wide = {DST_VAL, 1'b0} >> {28'h0, SRC_VAL[4:0]};
            res_d = wide[32:1];
            cy_d = wide[0];
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
            cy_upd = 1'b1;
         end
         exec_pkg::OP_RSHIFT_IMM: begin
            wide = {DST_VAL, 1'b0} >> {28'h0, SEL5};
            res_d = wide[32:1];
            cy_d = wide[0];
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
            cy_upd = 1'b1;
         end
         exec_pkg::OP_BYTE_WRITE: begin
            mem_we_d = 1'b1;
            wdata_d = {4{DST_VAL[7:0]}};
            be_d = 4'h1 << ag_ln.res[1:0];
         end
         exec_pkg::OP_HALF_WRITE: begin
            mem_we_d = 1'b1;
            wdata_d = {2{DST_VAL[15:0]}};
            be_d = 4'h3 << {ag_ln.res[1], 1'b0};
         end
         exec_pkg::OP_WORD_WRITE: begin
            mem_we_d = 1'b1;
            wdata_d = DST_VAL;
            be_d = 4'hf;
         end
         exec_pkg::OP_SYSREG_READ: begin
            res_d = sysreg_sel(SEL5, status_q);
            gpr_we_d = 1'b1;
         end
         exec_pkg::OP_INT_MINUS: begin
            wide = {1'b0, DST_VAL} - {1'b0, SRC_VAL};
            res_d = wide[31:0];
            cy_d = wide[32];
            ov_d = (DST_VAL[31] ^ SRC_VAL[31]) & (DST_VAL[31] ^ wide[31]);
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
            cy_upd = 1'b1;
         end
         exec_pkg::OP_FLOAT_MINUS: begin
            res_d = fp_ln.res;
            cy_d = fp_ln.cy;
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
            cy_upd = 1'b1;
         end
         exec_pkg::OP_SW_TRAP: begin
            trap_d = 1'b1;
         end
         exec_pkg::OP_FLOAT_TRUNC: begin
            res_d = fp_ln.res;
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
         end
         exec_pkg::OP_XOR_REG: begin
            res_d = DST_VAL ^ SRC_VAL;
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
         end
         exec_pkg::OP_XOR_IMM: begin
            res_d = {16'h0000, IMM16} ^ SRC_VAL;
            gpr_we_d = 1'b1;
            flags_upd = 1'b1;
         end
         exec_pkg::OP_BSTR_XOR: begin
            res_d = DST_VAL ^ SRC_VAL;
            bstr_we_d = 1'b1;
         end
         exec_pkg::OP_BSTR_XNOR: begin
            res_d = DST_VAL ^ ~SRC_VAL;
            bstr_we_d = 1'b1;
         end
         // code 15 is unused: it behaves as a no-op with no strobe other than DONE
         default: begin
         end
      endcase
   end

   // status word next value
   always_comb begin
      status_d = status_q;
      if (STATUS_WE) begin
         status_d = STATUS_WDATA;
      end
      if (OP_VALID && flags_upd) begin
         status_d[`PSW_S_BIT] = res_d[31];
         status_d[`PSW_Z_BIT] = (res_d == 32'h0000_0000);
         status_d[`PSW_OV_BIT] = ov_d;
         if (cy_upd) begin
            status_d[`PSW_CY_BIT] = cy_d;
         end
      end
      if (is_trap) begin
         status_d[`PSW_INTDIS_BIT] = 1'b1;
         status_d[`PSW_AFLT_BIT] = 1'b0;
         if (fis) begin
            status_d[`PSW_NMIP_BIT] = 1'b1;
         end else begin
            status_d[`PSW_INTDIS_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         status_q <= `PSW_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // the pair chosen depends on the status word before this trap
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         nrm_pc_q <= `SAVE_RESET;
         nrm_st_q <= `SAVE_RESET;
         fat_pc_q <= `SAVE_RESET;
         fat_st_q <= `SAVE_RESET;
      end else if (is_trap) begin
         if (fis) begin
            fat_pc_q <= RET_PC;
            fat_st_q <= status_q;
         end else begin
            nrm_pc_q <= RET_PC;
            nrm_st_q <= status_q;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         cause_q <= `CAUSE_RESET;
      end else if (is_trap) begin
         if (fis) begin
            cause_q[31:16] <= `TRAP_CODE_BASE + {11'h000, SEL5};
         end else begin
            cause_q[15:0] <= `TRAP_CODE_BASE + {11'h000, SEL5};
         end
      end
   end

   // registered outputs, one cycle after issue
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         done_q <= 1'b0;
         gpr_we_q <= 1'b0;
         bstr_we_q <= 1'b0;
         mem_we_q <= 1'b0;
         trap_q <= 1'b0;
      end else begin
         done_q <= OP_VALID;
         gpr_we_q <= OP_VALID && gpr_we_d;
         bstr_we_q <= OP_VALID && bstr_we_d;
         mem_we_q <= OP_VALID && mem_we_d;
         trap_q <= OP_VALID && trap_d;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         result_q <= 32'h0000_0000;
         addr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         be_q <= 4'h0;
         trap_pc_q <= 32'h0000_0000;
      end else if (OP_VALID) begin
         result_q <= res_d;
         addr_q <= ag_ln.res;
         wdata_q <= wdata_d;
         be_q <= mem_we_d ? be_d : 4'h0;
         trap_pc_q <= `TRAP_VEC_BASE + {23'h0, SEL5, 4'h0};
      end
   end

   assign DONE = done_q;
   assign GPR_WE = gpr_we_q;
   assign BSTR_WE = bstr_we_q;
   assign RESULT = result_q;
   assign MEM_WE = mem_we_q;
   assign MEM_ADDR = addr_q;
   assign MEM_WDATA = wdata_q;
   assign MEM_BE = be_q;
   assign TRAP_TAKEN = trap_q;
   assign TRAP_PC = trap_pc_q;
   assign STATUS = status_q;
endmodule

// ==== exec_unit_assertions.sv ====
`timescale 1ns/1ps
`include "exec_regs.svh"
module exec_unit_assertions (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // issue
   input wire logic OP_VALID,
   input wire exec_pkg::op_e OP_CODE,
   input wire exec_pkg::word_t SRC_VAL,
   input wire exec_pkg::word_t DST_VAL,
   input wire logic [15:0] IMM16,
   input wire logic [4:0] SEL5,
   input wire logic STATUS_WE,
   // results
   input wire logic GPR_WE,
   input wire logic BSTR_WE,
   input wire exec_pkg::word_t RESULT,
   input wire logic MEM_WE,
   input wire exec_pkg::word_t MEM_ADDR,
   input wire exec_pkg::word_t MEM_WDATA,
   input wire logic TRAP_TAKEN,
   input wire exec_pkg::word_t TRAP_PC,
   input wire exec_pkg::word_t STATUS
);
   exec_pkg::word_t disp;
   assign disp = {{16{IMM16[15]}}, IMM16};
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);
   // a same-cycle status load may overwrite flags, so such cycles are left out
   sequence issue_of(exec_pkg::op_e op);
      OP_VALID && OP_CODE == op && !STATUS_WE;
   endsequence
   sequence trap_entry;
      TRAP_TAKEN && STATUS[`PSW_INTDIS_BIT] && !STATUS[`PSW_AFLT_BIT];
   endsequence
   AST_LSHIFT_IMM: assert property (issue_of(exec_pkg::OP_LSHIFT_IMM) |=> GPR_WE
      && RESULT == $past(DST_VAL) << $past(SEL5) && !STATUS[`PSW_OV_BIT]) else $error("lshift");
   AST_RSHIFT_REG: assert property (issue_of(exec_pkg::OP_RSHIFT_REG) |=> GPR_WE
      && RESULT == $past(DST_VAL) >> ($past(SRC_VAL) & 32'h1f)) else $error("rshift");
   AST_BYTE_WRITE: assert property (issue_of(exec_pkg::OP_BYTE_WRITE) |=> MEM_WE
      && MEM_ADDR == $past(SRC_VAL) + $past(disp)
      && ((MEM_WDATA ^ $past(DST_VAL)) & 32'hff) == 32'h0) else $error("byte write");
   AST_HALF_WRITE: assert property (issue_of(exec_pkg::OP_HALF_WRITE) |=> MEM_WE
      && MEM_ADDR == $past(SRC_VAL) + ($past(disp) & 32'hffff_fffe)
      && ((MEM_WDATA ^ $past(DST_VAL)) & 32'hffff) == 32'h0) else $error("half write");
   AST_WORD_WRITE: assert property (issue_of(exec_pkg::OP_WORD_WRITE) |=> MEM_WE
      && MEM_ADDR == $past(SRC_VAL) + ($past(disp) & 32'hffff_fffc)
      && MEM_WDATA == $past(DST_VAL)) else $error("word write");
   AST_SYSREG_FLAGS: assert property (issue_of(exec_pkg::OP_SYSREG_READ) |=>
      GPR_WE && $stable(STATUS)) else $error("sysreg read moved status");
   AST_INT_MINUS: assert property (issue_of(exec_pkg::OP_INT_MINUS) |=>
      RESULT == $past(DST_VAL) - $past(SRC_VAL) && STATUS[`PSW_S_BIT] == RESULT[31]
      && STATUS[`PSW_Z_BIT] == (RESULT == 32'h0)) else $error("int minus");
   AST_TRAP: assert property (issue_of(exec_pkg::OP_SW_TRAP) |=> trap_entry
      ##0 TRAP_PC == `TRAP_VEC_BASE + ($past(SEL5) << 4)) else $error("trap entry");
   AST_TRAP_NMI: assert property (issue_of(exec_pkg::OP_SW_TRAP) ##0 STATUS[`PSW_FIS_BIT]
      |=> STATUS[`PSW_NMIP_BIT]) else $error("nmi pending not set");
   AST_BSTR_XOR: assert property (issue_of(exec_pkg::OP_BSTR_XOR) |=> BSTR_WE && !GPR_WE
      && RESULT == ($past(SRC_VAL) ^ $past(DST_VAL)) && $stable(STATUS)) else $error("bstr");
endmodule
bind exec_unit exec_unit_assertions i_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .OP_VALID(OP_VALID),
   .OP_CODE(OP_CODE), .SRC_VAL(SRC_VAL), .DST_VAL(DST_VAL), .IMM16(IMM16), .SEL5(SEL5),
   .STATUS_WE(STATUS_WE), .GPR_WE(GPR_WE), .BSTR_WE(BSTR_WE), .RESULT(RESULT),
   .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .TRAP_TAKEN(TRAP_TAKEN),
   .TRAP_PC(TRAP_PC), .STATUS(STATUS));

// ==== exec_unit_test.sv ====
`timescale 1ns/1ps
`include "exec_regs.svh"
module exec_unit_test;
   logic CORE_CLK = 1'b0;
   logic NRST = 1'b0;
   logic OP_VALID = 1'b0;
   logic STATUS_WE = 1'b0;
   exec_pkg::op_e OP_CODE = exec_pkg::OP_XOR_REG;
   exec_pkg::word_t SRC_VAL = 32'h0;
   exec_pkg::word_t DST_VAL = 32'h0;
   exec_pkg::word_t RET_PC = 32'h0;
   exec_pkg::word_t STATUS_WDATA = 32'h0;
   logic [15:0] IMM16 = 16'h0;
   logic [4:0] SEL5 = 5'h0;
   logic DONE, GPR_WE, BSTR_WE, MEM_WE, TRAP_TAKEN;
   logic [3:0] MEM_BE;
   exec_pkg::word_t RESULT, MEM_ADDR, MEM_WDATA, TRAP_PC, STATUS, st, pc;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   exec_unit i_dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
      .SRC_VAL(SRC_VAL), .DST_VAL(DST_VAL), .IMM16(IMM16), .SEL5(SEL5), .RET_PC(RET_PC),
      .STATUS_WE(STATUS_WE), .STATUS_WDATA(STATUS_WDATA), .DONE(DONE), .GPR_WE(GPR_WE),
      .BSTR_WE(BSTR_WE), .RESULT(RESULT), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_BE(MEM_BE), .TRAP_TAKEN(TRAP_TAKEN), .TRAP_PC(TRAP_PC),
      .STATUS(STATUS));

   always #2 CORE_CLK = ~CORE_CLK;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // whole run needs about 60 cycles
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         finish_test();
      end
   end

   task automatic check(input exec_pkg::word_t seen, input exec_pkg::word_t exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // the low imm bits double as the 5-bit select field
   task automatic issue(input exec_pkg::op_e op, input exec_pkg::word_t src,
         input exec_pkg::word_t dst, input logic [15:0] imm);
      @(posedge CORE_CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= op;
      SRC_VAL <= src;
      DST_VAL <= dst;
      IMM16 <= imm;
      SEL5 <= imm[4:0];
      RET_PC <= pc;
      @(posedge CORE_CLK);
      OP_VALID <= 1'b0;
      #1;
      check({31'h0, DONE}, 32'h1);
   endtask

   // co is {carry, overflow}; st is the bench's own status model
   task automatic alu(input exec_pkg::op_e op, input exec_pkg::word_t src,
         input exec_pkg::word_t dst, input logic [15:0] imm, input exec_pkg::word_t res,
         input logic [1:0] co);
      logic bstr;
      logic [1:0] c;
      bstr = op inside {exec_pkg::OP_BSTR_XOR, exec_pkg::OP_BSTR_XNOR};
      c = co;
      if (op inside {exec_pkg::OP_FLOAT_TRUNC, exec_pkg::OP_XOR_REG, exec_pkg::OP_XOR_IMM}) begin
         c[1] = st[`PSW_CY_BIT];
      end
      issue(op, src, dst, imm);
      if (!bstr && op != exec_pkg::OP_SYSREG_READ) begin
         st[3:0] = {c, res[31], res == 32'h0};
      end
      check(RESULT, res);
      check(STATUS, st);
      check({30'h0, GPR_WE, BSTR_WE}, {30'h0, !bstr, bstr});
   endtask

   task automatic mem(input exec_pkg::op_e op, input exec_pkg::word_t src,
         input exec_pkg::word_t dst, input logic [15:0] imm, input exec_pkg::word_t addr,
         input exec_pkg::word_t lanes, input logic [3:0] be);
      issue(op, src, dst, imm);
      check({31'h0, MEM_WE}, 32'h1);
      check({28'h0, MEM_BE}, {28'h0, be});
      check(MEM_ADDR, addr);
      check(MEM_WDATA & lanes, dst & lanes);
      check(STATUS, st);
   endtask

   task automatic trap(input logic [4:0] v, input exec_pkg::word_t ret);
      exec_pkg::word_t old;
      logic fis;
      old = st;
      fis = st[`PSW_FIS_BIT];
      pc = ret;
      issue(exec_pkg::OP_SW_TRAP, 32'h0, 32'h0, {11'h0, v});
      st[`PSW_INTDIS_BIT] = 1'b1;
      st[`PSW_AFLT_BIT] = 1'b0;
      st[`PSW_NMIP_BIT] = st[`PSW_NMIP_BIT] | fis;
      check({31'h0, TRAP_TAKEN}, 32'h1);
      check(TRAP_PC, `TRAP_VEC_BASE + {27'h0, v} * 32'h10);
      check(STATUS, st);
      alu(exec_pkg::OP_SYSREG_READ, 32'h0, 32'h0, {11'h0, fis ? `SR_FAT_PC : `SR_NRM_PC},
         ret, 2'h0);
      alu(exec_pkg::OP_SYSREG_READ, 32'h0, 32'h0, {11'h0, fis ? `SR_FAT_ST : `SR_NRM_ST},
         old, 2'h0);
      issue(exec_pkg::OP_SYSREG_READ, 32'h0, 32'h0, {11'h0, `SR_CAUSE});
      check(fis ? RESULT >> 16 : RESULT & 32'hffff, {16'h0, `TRAP_CODE_BASE + {11'h0, v}});
   endtask

   task automatic load(input exec_pkg::word_t w);
      @(posedge CORE_CLK);
      STATUS_WE <= 1'b1;
      STATUS_WDATA <= w;
      @(posedge CORE_CLK);
      STATUS_WE <= 1'b0;
      st = w;
   endtask

   initial begin
      pc = 32'h0;
      st = `PSW_RESET;
      repeat (12) @(posedge CORE_CLK);
      NRST <= 1'b1;
      alu(exec_pkg::OP_INT_MINUS, 32'h7, 32'h5, 16'h0, 32'hffff_fffe, 2'h2);
      alu(exec_pkg::OP_INT_MINUS, 32'h1, 32'h8000_0000, 16'h0, 32'h7fff_ffff, 2'h1);
      alu(exec_pkg::OP_LSHIFT_IMM, 32'h0, 32'h3, 16'h1f, 32'h8000_0000, 2'h2);
      alu(exec_pkg::OP_RSHIFT_REG, 32'h21, 32'h8000_0003, 16'h3, 32'h4000_0001, 2'h2);
      alu(exec_pkg::OP_RSHIFT_IMM, 32'h1f, 32'hf8, 16'h4, 32'hf, 2'h2);
      alu(exec_pkg::OP_FLOAT_MINUS, 32'h4040_0000, 32'h3f80_0000, 16'h0,
         32'hc000_0000, 2'h2);
      alu(exec_pkg::OP_FLOAT_TRUNC, 32'hc020_0000, 32'h0, 16'h0, 32'hffff_fffe, 2'h0);
      alu(exec_pkg::OP_XOR_REG, 32'h5a5a_5a5a, 32'h5a5a_5a5a, 16'h0, 32'h0, 2'h0);
      alu(exec_pkg::OP_XOR_IMM, 32'hffff_0000, 32'h1, 16'h8001, 32'hffff_8001, 2'h0);
      alu(exec_pkg::OP_BSTR_XOR, 32'h0f0f_0f0f, 32'h00ff_00ff, 16'h0, 32'h0ff0_0ff0, 2'h0);
      alu(exec_pkg::OP_BSTR_XNOR, 32'h0f0f_0f0f, 32'h00ff_00ff, 16'h0,
         32'hf00f_f00f, 2'h0);
      mem(exec_pkg::OP_BYTE_WRITE, 32'h100, 32'h1234_56ab, 16'hffff, 32'hff, 32'hff, 4'h8);
      mem(exec_pkg::OP_HALF_WRITE, 32'h101, 32'h1234_cdef, 16'h3, 32'h103, 32'hffff, 4'hc);
      mem(exec_pkg::OP_WORD_WRITE, 32'h100, 32'h89ab_cdef, 16'h8007, 32'hffff_8104,
         32'hffff_ffff, 4'hf);
      trap(5'h1f, 32'h1234);
      load(32'h0000_6003);
      trap(5'h0, 32'h5678);
      alu(exec_pkg::OP_SYSREG_READ, 32'h0, 32'h0, {11'h0, `SR_NRM_PC}, 32'h1234, 2'h0);
      alu(exec_pkg::OP_SYSREG_READ, 32'h0, 32'h0, {11'h0, `SR_STATUS}, st, 2'h0);
      finish_test();
   end
endmodule

// ==== fp_unit.sv ====
`timescale 1ns/1ps
`include "exec_regs.svh"
// single precision, denormals flushed to zero, results truncated toward zero
module fp_unit (
   op_lane_if.unit ln
);
   logic [7:0] ea, eb, el, es, ediff;
   logic [23:0] ma, mb, ml, ms;
   logic sa, sb, sl, swap;
   logic [27:0] ext_s, sum, norm;
   logic [4:0] lz;
   logic [9:0] er;
   exec_pkg::word_t fsub_res, trunc_res, mag;

   function automatic logic [4:0] lead_zeros(input logic [27:0] v);
      logic [4:0] n;
      n = 5'd27;
      for (int i = 0; i < 27; i++) begin
         if (v[i]) begin
            n = 5'(26 - i);
         end
      end
      return n;
   endfunction

   always_comb begin
      ea = ln.a[30:23];
      eb = ln.b[30:23];
      ma = (ea == 8'h00) ? 24'h0 : {1'b1, ln.a[22:0]};
      mb = (eb == 8'h00) ? 24'h0 : {1'b1, ln.b[22:0]};
      sa = ln.a[31];
      sb = ~ln.b[31];
      swap = {ea, ma} < {eb, mb};
      el = swap ? eb : ea;
      es = swap ? ea : eb;
      ml = swap ? mb : ma;
      ms = swap ? ma : mb;
      sl = swap ? sb : sa;
      ediff = el - es;
      ext_s = (ediff > 8'd27) ? 28'h0 : ({1'b0, ms, 3'b000} >> ediff);
      sum = (sa == sb) ? ({1'b0, ml, 3'b000} + ext_s) : ({1'b0, ml, 3'b000} - ext_s);
      lz = lead_zeros(sum);
      if (sum[27]) begin
         norm = sum >> 1;
         er = {2'b00, el} + 10'd1;
      end else begin
         norm = sum << lz;
         er = {2'b00, el} - {5'b00000, lz};
      end
      if (ea == 8'hff) begin
         fsub_res = ln.a;
      end else if (eb == 8'hff) begin
         fsub_res = {~ln.b[31], ln.b[30:0]};
      end else if (sum == 28'h0 || er[9] || er == 10'h0) begin
         // exact cancellation gives +0 so the zero flag sees all zeros
         fsub_res = 32'h0000_0000;
      end else if (er >= 10'h0ff) begin
         fsub_res = {sl, 8'hff, 23'h0};
      end else begin
         fsub_res = {sl, er[7:0], norm[25:3]};
      end
   end

   // out-of-range values saturate to the most negative integer
   always_comb begin
      mag = {1'b1, ln.b[22:0], 8'h00} >> (8'd158 - eb);
      if (eb < 8'd127) begin
         trunc_res = 32'h0000_0000;
      end else if (eb > 8'd157) begin
         trunc_res = 32'h8000_0000;
      end else begin
         trunc_res = ln.b[31] ? (32'h0 - mag) : mag;
      end
   end

   assign ln.res = (ln.sel == `LANE_FTRUNC) ? trunc_res : fsub_res;
   assign ln.cy = ln.res[31];
endmodule

// ==== op_lane_if.sv ====
`timescale 1ns/1ps
interface op_lane_if;
   exec_pkg::word_t a;
   exec_pkg::word_t b;
   logic [15:0] imm;
   logic [1:0] sel;
   exec_pkg::word_t res;
   logic cy;

   modport core (output a, output b, output imm, output sel, input res, input cy);
   modport unit (input a, input b, input imm, input sel, output res, output cy);
endinterface
